//--- rtcb_ctrl.sv
// Behaviour
// - compensation select picks 0.5 s, 2 s (reset), 10 s or 30 s period.
// - update flag rising drives interrupt low only when update enable set.
// - update interrupt self-releases after 7.813 ms; enable cleared cancels.
// - timer flag rising drives interrupt low when timer enable set.
// - timer interrupt self-releases after 7.813 ms, no software needed.
// - alarm flag rising drives interrupt low when alarm enable set.
// - alarm interrupt holds until alarm flag or alarm enable is cleared; no auto release.
// - writing 1 to resync only arms it; host ends transfer with stop.
// - armed resync runs at the next stop, then the bit clears itself.
// - repeated start never triggers an armed resync.
// - resync clears the divider stages from 16 kHz down to 1 Hz.
// - next second comes 1000 ms minus one tick to 1000 ms after resync.
// - resync shifts update, alarm and timer timing via the divider.
// - read-only thermal code, refreshed at each compensation run.
// - monitor disable bit 3 turns switchover and comparator off.
// - comparator enable rises 62.5 ms after each seconds increment.
// - sample-time field sets how long the comparator stays on.
// - normal mode samples each second, enters backup at or below threshold.
// - backup mode keeps switch off, returns to normal above threshold.
// - switch-off bit drives the reverse-current blocking switch.
// - event flags set by events, held until software writes 0.
// - control register at 0F/1F: select, enables, zero bits, resync.
module rtcb_ctrl #(
  parameter int RTN_CYC = rtcb_pkg::RTN_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   linkClk,
  input  wire logic                   osc32k,
  input  wire logic                   vddLow,
  input  wire logic                   updateEvent,
  input  wire logic                   timerEvent,
  input  wire logic                   alarmEvent,
  input  wire logic [7:0]             tempCode,
  input  wire logic                   linkWrStrobe,
  input  wire logic                   linkRdStrobe,
  input  wire logic                   linkStop,
  input  wire logic                   linkRestart,
  input  wire logic [4:0]             linkAddr,
  input  wire logic [7:0]             linkWrData,
  output logic                        linkBusy,
  output logic [7:0]                  linkRdData,
  output logic                        linkRdValid,
  output logic                        intOut,
  output logic                        intOe_b,
  output logic [rtcb_pkg::DIV_W-1:0]  prescaler,
  output logic                        secondPulse,
  output logic                        compStart,
  output logic                        comparator_window_enable,
  output logic                        supplySwitchOff,
  output logic                        backupMode
);
  import rtcb_pkg::*;

  // -------------------------------------------------------------------
  // resets and synchronisers
  // -------------------------------------------------------------------
  logic       rstS1_reg, rstS2_reg, lrstS1_reg, lrstS2_reg;
  logic [2:0] oscS_reg;
  logic [1:0] vddS_reg;
  logic       reqTogS1_reg, reqTogS2_reg, reqTogS3_reg;
  logic       stopTogS1_reg, stopTogS2_reg, stopTogS3_reg;
  logic       ackTogS1_reg, ackTogS2_reg, ackTogS3_reg;
  logic       reqTog_reg, stopTog_reg, ackTog_reg;

  // core reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstS1_reg <= 1'b0;
      rstS2_reg <= 1'b0;
    end else begin
      rstS1_reg <= 1'b1;
      rstS2_reg <= rstS1_reg;
    end
  end

  // link-side reset release, same scheme on the link clock
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      lrstS1_reg <= 1'b0;
      lrstS2_reg <= 1'b0;
    end else begin
      lrstS1_reg <= 1'b1;
      lrstS2_reg <= lrstS1_reg;
    end
  end

  // pins and link toggles into the core clock; third stage only for edges
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      oscS_reg      <= 3'h0;
      vddS_reg      <= 2'h0;
      reqTogS1_reg  <= 1'b0;
      reqTogS2_reg  <= 1'b0;
      reqTogS3_reg  <= 1'b0;
      stopTogS1_reg <= 1'b0;
      stopTogS2_reg <= 1'b0;
      stopTogS3_reg <= 1'b0;
    end else begin
      oscS_reg      <= {oscS_reg[1:0], osc32k};
      vddS_reg      <= {vddS_reg[0], vddLow};
      reqTogS1_reg  <= reqTog_reg;
      reqTogS2_reg  <= reqTogS1_reg;
      reqTogS3_reg  <= reqTogS2_reg;
      stopTogS1_reg <= stopTog_reg;
      stopTogS2_reg <= stopTogS1_reg;
      stopTogS3_reg <= stopTogS2_reg;
    end
  end

  logic tick, reqSeen, stopSeen, vddIsLow;
  assign tick     = oscS_reg[1] & ~oscS_reg[2];
  assign reqSeen  = reqTogS2_reg ^ reqTogS3_reg;
  assign stopSeen = stopTogS2_reg ^ stopTogS3_reg;
  assign vddIsLow = vddS_reg[1];

  // -------------------------------------------------------------------
  // link domain: one request in flight, held stable until acknowledged
  // -------------------------------------------------------------------
  rtcb_req_t reqHold_reg;
  logic [7:0] ackData_reg;

  // ack toggle back into the link clock
  always_ff @(posedge linkClk or negedge lrstS2_reg) begin
    if (!lrstS2_reg) begin
      ackTogS1_reg <= 1'b0;
      ackTogS2_reg <= 1'b0;
      ackTogS3_reg <= 1'b0;
    end else begin
      ackTogS1_reg <= ackTog_reg;
      ackTogS2_reg <= ackTogS1_reg;
      ackTogS3_reg <= ackTogS2_reg;
    end
  end

  // capture a request; strobes while busy are dropped
  always_ff @(posedge linkClk or negedge lrstS2_reg) begin
    if (!lrstS2_reg) begin
      reqHold_reg <= '0;
      reqTog_reg  <= 1'b0;
      linkBusy    <= 1'b0;
    end else if ((linkWrStrobe | linkRdStrobe) & ~linkBusy) begin
      reqHold_reg <= '{isWrite: linkWrStrobe, addr: linkAddr,
                       data: linkWrData};
      reqTog_reg  <= ~reqTog_reg;
      linkBusy    <= 1'b1;
    end else if (ackTogS2_reg != reqTog_reg) begin
      linkBusy    <= linkBusy;
    end else begin
      linkBusy    <= 1'b0;
    end
  end

  // stop crosses as its own toggle; restart is deliberately not passed
  always_ff @(posedge linkClk or negedge lrstS2_reg) begin
    if (!lrstS2_reg) begin
      stopTog_reg <= 1'b0;
    end else if (linkStop & ~linkRestart) begin
      stopTog_reg <= ~stopTog_reg;
    end
  end

  // read answer; ack data is stable once the ack toggle has landed
  always_ff @(posedge linkClk or negedge lrstS2_reg) begin
    if (!lrstS2_reg) begin
      linkRdData  <= 8'h00;
      linkRdValid <= 1'b0;
    end else begin
      linkRdValid <= (ackTogS2_reg ^ ackTogS3_reg) & ~reqHold_reg.isWrite;
      if ((ackTogS2_reg ^ ackTogS3_reg) & ~reqHold_reg.isWrite) begin
        linkRdData <= ackData_reg;
      end
    end
  end

  // -------------------------------------------------------------------
  // register file in the core domain
  // -------------------------------------------------------------------
  logic [7:0] ctrl_reg, flag_reg, bkp_reg, therm_reg;
  logic       wrCtrl, wrFlag, wrBkp, resyncNow;

  function automatic logic isAddr(input logic [4:0] a,
                                  input logic [4:0] lo,
                                  input logic [4:0] hi);
    return (a == lo) || (a == hi);
  endfunction

  assign wrCtrl = reqSeen & reqHold_reg.isWrite &
                  isAddr(reqHold_reg.addr, ADDR_CTRL_LO, ADDR_CTRL_HI);
  assign wrFlag = reqSeen & reqHold_reg.isWrite &
                  isAddr(reqHold_reg.addr, ADDR_FLAG_LO, ADDR_FLAG_HI);
  assign wrBkp  = reqSeen & reqHold_reg.isWrite &
                  (reqHold_reg.addr == ADDR_BACKUP);

  // a stop landing with the arming write still runs: the write comes first
  assign resyncNow = stopSeen &
                     (ctrl_reg[CTRL_RESYNC] |
                      (wrCtrl & reqHold_reg.data[CTRL_RESYNC]));

  // control register, zero bits 2:1 kept clear by the write mask
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      ctrl_reg <= CTRL_RESET;
    end else if (resyncNow) begin
      ctrl_reg <= (wrCtrl ? (reqHold_reg.data & CTRL_WMASK) : ctrl_reg)
                  & ~(8'h01 << CTRL_RESYNC);
    end else if (wrCtrl) begin
      ctrl_reg <= reqHold_reg.data & CTRL_WMASK;
    end
  end

  // sticky flags: an event in the clearing cycle wins
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      flag_reg <= 8'h00;
    end else begin
      flag_reg <= ((wrFlag ? (flag_reg & reqHold_reg.data) : flag_reg)
                   | {2'b00, updateEvent, timerEvent, alarmEvent, 3'b000})
                  & FLAG_MASK;
    end
  end

  // backup control, upper nibble never stored
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      bkp_reg <= BKP_RESET;
    end else if (wrBkp) begin
      bkp_reg <= reqHold_reg.data & BKP_WMASK;
    end
  end

  // answer every request; unmapped addresses read zero
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      ackTog_reg  <= 1'b0;
      ackData_reg <= 8'h00;
    end else if (reqSeen) begin
      ackTog_reg <= ~ackTog_reg;
      if (isAddr(reqHold_reg.addr, ADDR_CTRL_LO, ADDR_CTRL_HI)) begin
        ackData_reg <= ctrl_reg;
      end else if (isAddr(reqHold_reg.addr, ADDR_FLAG_LO,
                          ADDR_FLAG_HI)) begin
        ackData_reg <= flag_reg;
      end else if (reqHold_reg.addr == ADDR_THERMAL) begin
        ackData_reg <= therm_reg;
      end else if (reqHold_reg.addr == ADDR_BACKUP) begin
        ackData_reg <= bkp_reg;
      end else begin
        ackData_reg <= 8'h00;
      end
    end
  end

  // -------------------------------------------------------------------
  // interrupt sources
  // -------------------------------------------------------------------
  logic        updAct_reg, tmrAct_reg, almAct_reg;
  logic [20:0] updCnt_reg, tmrCnt_reg;
  logic        updRise, tmrRise, almRise, updOff, tmrOff, almOff;

  assign updRise = updateEvent & ~flag_reg[FLAG_UPD];
  assign tmrRise = timerEvent  & ~flag_reg[FLAG_TMR];
  assign almRise = alarmEvent  & ~flag_reg[FLAG_ALM];
  assign updOff  = wrCtrl & ~reqHold_reg.data[CTRL_UPD_EN];
  assign tmrOff  = wrCtrl & ~reqHold_reg.data[CTRL_TMR_EN];
  assign almOff  = wrCtrl & ~reqHold_reg.data[CTRL_ALM_EN];

  // update source: timed hold, cancelled by clearing its enable
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      updAct_reg <= 1'b0;
      updCnt_reg <= '0;
    end else if (updRise & ctrl_reg[CTRL_UPD_EN]) begin
      updAct_reg <= 1'b1;
      updCnt_reg <= 21'(RTN_CYC - 1);
    end else if (updOff | (updAct_reg & (updCnt_reg == '0))) begin
      updAct_reg <= 1'b0;
    end else if (updAct_reg) begin
      updCnt_reg <= updCnt_reg - 21'h000001;
    end
  end

  // timer source: same timed hold, flag clearing does not release it
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      tmrAct_reg <= 1'b0;
      tmrCnt_reg <= '0;
    end else if (tmrRise & ctrl_reg[CTRL_TMR_EN]) begin
      tmrAct_reg <= 1'b1;
      tmrCnt_reg <= 21'(RTN_CYC - 1);
    end else if (tmrOff) begin
      tmrAct_reg <= 1'b0;
    end else if (tmrAct_reg & (tmrCnt_reg == '0)) begin
      tmrAct_reg <= 1'b0;
    end else if (tmrAct_reg) begin
      tmrCnt_reg <= tmrCnt_reg - 21'h000001;
    end
  end

  // alarm source: no timeout, only flag clear or enable clear release it
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      almAct_reg <= 1'b0;
    end else if (almRise & ctrl_reg[CTRL_ALM_EN]) begin
      almAct_reg <= 1'b1;
    end else if (almOff | ~flag_reg[FLAG_ALM]) begin
      almAct_reg <= 1'b0;
    end
  end

  // open-drain pin: data held low, enable low while any source pulls
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      intOut  <= 1'b0;
      intOe_b <= 1'b1;
    end else begin
      intOut  <= 1'b0;
      intOe_b <= ~(updAct_reg | tmrAct_reg | almAct_reg);
    end
  end

  // -------------------------------------------------------------------
  // prescaler chain and compensation timing
  // -------------------------------------------------------------------
  logic [6:0] compCnt_reg, compTarget;
  logic       halfTick, secTick;

  assign halfTick = tick & (prescaler[HALF_SEC_BIT:0] == '1);
  assign secTick  = tick & (prescaler == '1);

  // clearing the 1 Hz stage too makes the next second a full period away
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      prescaler   <= '0;
      secondPulse <= 1'b0;
    end else begin
      secondPulse <= secTick & ~resyncNow;
      if (resyncNow) begin
        prescaler <= '0;
      end else if (tick) begin
        prescaler <= prescaler + 15'h0001;
      end
    end
  end

  always_comb begin
    unique case (ctrl_reg[CTRL_CSEL_HI:CTRL_CSEL_LO])
      2'b00: compTarget = COMP_HALVES_0;
      2'b01: compTarget = COMP_HALVES_1;
      2'b10: compTarget = COMP_HALVES_2;
      2'b11: compTarget = COMP_HALVES_3;
    endcase
  end

  // compensation run every selected interval; thermal code latched then
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      compCnt_reg <= '0;
      compStart   <= 1'b0;
      therm_reg   <= THERM_RESET;
    end else begin
      compStart <= 1'b0;
      if (halfTick & ~resyncNow) begin
        if (compCnt_reg + 7'h01 >= compTarget) begin
          compCnt_reg <= '0;
          compStart   <= 1'b1;
          therm_reg   <= tempCode;
        end else begin
          compCnt_reg <= compCnt_reg + 7'h01;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // backup switchover
  // -------------------------------------------------------------------
  rtcb_pwr_t   pwr_reg;
  logic [11:0] pwrCnt_reg, sampTicks;
  logic        monOff;

  assign monOff = bkp_reg[BKP_VDD_MONOFF];

  always_comb begin
    unique case (bkp_reg[1:0])
      2'b00: sampTicks = SAMP_TICKS_0;
      2'b01: sampTicks = SAMP_TICKS_1;
      2'b10: sampTicks = SAMP_TICKS_2;
      2'b11: sampTicks = SAMP_TICKS_3;
    endcase
  end

  // once a second: wait, open the comparator window, judge at its end
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      pwr_reg    <= PWR_IDLE;
      pwrCnt_reg <= '0;
      comparator_window_enable     <= 1'b0;
      backupMode <= 1'b0;
    end else if (monOff) begin
      pwr_reg    <= PWR_IDLE;
      comparator_window_enable     <= 1'b0;
      backupMode <= 1'b0;
    end else begin
      unique case (pwr_reg)
        PWR_IDLE: if (secTick) begin
          pwr_reg    <= PWR_DELAY;
          pwrCnt_reg <= COMPARATOR_WINDOW_ENABLE_DLY_TICKS - 12'h001;
        end
        PWR_DELAY: if (tick) begin
          if (pwrCnt_reg == '0) begin
            pwr_reg    <= PWR_WINDOW;
            comparator_window_enable     <= 1'b1;
            pwrCnt_reg <= sampTicks - 12'h001;
          end else begin
            pwrCnt_reg <= pwrCnt_reg - 12'h001;
          end
        end
        PWR_WINDOW: if (tick) begin
          if (pwrCnt_reg == '0) begin
            pwr_reg    <= PWR_IDLE;
            comparator_window_enable     <= 1'b0;
            backupMode <= vddIsLow;
          end else begin
            pwrCnt_reg <= pwrCnt_reg - 12'h001;
          end
        end
      endcase
    end
  end

  // switch opens during each window in normal mode, stays open in backup
  always_ff @(posedge clk or negedge rstS2_reg) begin
    if (!rstS2_reg) begin
      supplySwitchOff <= 1'b0;
    end else begin
      supplySwitchOff <= bkp_reg[BKP_SW_OFF] |
                         (~monOff & (backupMode |
                          (pwr_reg == PWR_WINDOW)));
    end
  end

endmodule // rtcb_ctrl

//--- rtcb_pkg.sv
package rtcb_pkg;

  // -------------------------------------------------------------------
  // register map (address = register number on the serial bus)
  // -------------------------------------------------------------------
  localparam logic [4:0] ADDR_FLAG_LO   = 5'h0E;
  localparam logic [4:0] ADDR_FLAG_HI   = 5'h1E;
  localparam logic [4:0] ADDR_CTRL_LO   = 5'h0F;
  localparam logic [4:0] ADDR_CTRL_HI   = 5'h1F;
  localparam logic [4:0] ADDR_THERMAL   = 5'h17;
  localparam logic [4:0] ADDR_BACKUP    = 5'h18;

  // -------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------
  localparam int CTRL_CSEL_HI   = 7;
  localparam int CTRL_CSEL_LO   = 6;
  localparam int CTRL_UPD_EN    = 5;
  localparam int CTRL_TMR_EN    = 4;
  localparam int CTRL_ALM_EN    = 3;
  localparam int CTRL_RESYNC    = 0;
  localparam int FLAG_UPD       = 5;
  localparam int FLAG_TMR       = 4;
  localparam int FLAG_ALM       = 3;
  localparam int BKP_VDD_MONOFF = 3;
  localparam int BKP_SW_OFF     = 2;
  localparam logic [7:0] CTRL_RESET  = 8'h40;
  localparam logic [7:0] CTRL_WMASK  = 8'hF9;
  localparam logic [7:0] FLAG_MASK   = 8'h38;
  localparam logic [7:0] BKP_WMASK   = 8'h0F;
  localparam logic [7:0] BKP_RESET   = 8'h00;
  localparam logic [7:0] THERM_RESET = 8'h00;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_KHZ        = 250000;
  localparam int TICK_HZ        = 32768;
  localparam int RTN_NS         = 7813000;
  localparam int RTN_CYCLES     = RTN_NS / 1000 * (CLK_KHZ / 1000);
  localparam int COMPARATOR_WINDOW_ENABLE_DLY_US  = 62500;
  localparam logic [11:0] COMPARATOR_WINDOW_ENABLE_DLY_TICKS =
    12'((COMPARATOR_WINDOW_ENABLE_DLY_US * 64 / 1000 * TICK_HZ / 64000));
  localparam int DIV_W          = 15;
  localparam int HALF_SEC_BIT   = 13;
  // compensation intervals in half-second steps: 0.5 s, 2 s, 10 s, 30 s
  localparam logic [6:0] COMP_HALVES_0 = 7'h01;
  localparam logic [6:0] COMP_HALVES_1 = 7'h04;
  localparam logic [6:0] COMP_HALVES_2 = 7'h14;
  localparam logic [6:0] COMP_HALVES_3 = 7'h3C;
  // comparator window lengths in 32 kHz ticks, per sample-time select
  localparam logic [11:0] SAMP_TICKS_0 = 12'h001;
  localparam logic [11:0] SAMP_TICKS_1 = 12'h002;
  localparam logic [11:0] SAMP_TICKS_2 = 12'h004;
  localparam logic [11:0] SAMP_TICKS_3 = 12'h008;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef struct packed {
    logic       isWrite;
    logic [4:0] addr;
    logic [7:0] data;
  } rtcb_req_t;

  typedef enum logic [1:0] {PWR_IDLE, PWR_DELAY, PWR_WINDOW} rtcb_pwr_t;

endpackage

//--- rtcb_ctrl_chk.sv
module rtcb_ctrl_chk #(
  parameter int RTN_CYC = 20
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        linkClk,
  input wire logic        updateEvent,
  input wire logic        timerEvent,
  input wire logic        alarmEvent,
  input wire logic        linkWrStrobe,
  input wire logic        linkBusy,
  input wire logic [7:0]  linkRdData,
  input wire logic        linkRdValid,
  input wire logic        intOut,
  input wire logic        intOe_b,
  input wire logic [14:0] prescaler,
  input wire logic        comparator_window_enable,
  input wire logic        backupMode
);
  timeunit 1ns;
  timeprecision 1ps;
  // any source, so a falling interrupt can be traced to its cause
  wire logic anyEvent = updateEvent | timerEvent | alarmEvent;

  // core domain: pin only pulled low, and never without an event
  od_data_a: assert property (@(posedge clk) disable iff (!rst_b)
    intOut == 1'b0) else $error("interrupt data bit not low");
  int_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(intOe_b) |-> $past(anyEvent, 2)) else $error("int w/o event");
  int_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(intOe_b) |-> !intOe_b [*4]) else $error("interrupt too short");
  presc_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(prescaler) && prescaler != 15'h0000
      |-> prescaler == $past(prescaler) + 15'h0001)
    else $error("divider skipped a count");
  mode_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(backupMode) |-> $past(comparator_window_enable) || $past(comparator_window_enable, 2))
    else $error("backup entered without comparison");

  // link domain: take, bounded busy, one-cycle valid, held read data
  busy_take_a: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkWrStrobe && !linkBusy |=> linkBusy) else $error("write not taken");
  busy_bound_a: assert property (@(posedge linkClk) disable iff (!rst_b)
    $rose(linkBusy) |-> ##[1:40] !linkBusy) else $error("busy hangs");
  rdv_pulse_a: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkRdValid |=> !linkRdValid) else $error("read valid too long");
  rdata_hold_a: assert property (@(posedge linkClk) disable iff (!rst_b)
    $changed(linkRdData) |-> linkRdValid) else $error("read data moved");
endmodule // rtcb_ctrl_chk

//--- rtcb_host.sv
module rtcb_host (
  input  wire logic       linkClk,
  input  wire logic       linkBusy,
  input  wire logic       linkRdValid,
  input  wire logic [7:0] linkRdData,
  output logic            linkWrStrobe,
  output logic            linkRdStrobe,
  output logic            linkStop,
  output logic            linkRestart,
  output logic [4:0]      linkAddr,
  output logic [7:0]      linkWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {linkWrStrobe, linkRdStrobe, linkStop, linkRestart} = 4'h0;
    linkAddr = 5'h00;
    linkWrData = 8'h00;
  end
  // one byte access; released lines show the inverse, not stale data
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    q = 8'hXX; // a read that never answers can then never match
    @(negedge linkClk);
    {linkAddr, linkWrData, linkWrStrobe, linkRdStrobe} = {a, d, wr, !wr};
    @(negedge linkClk);
    {linkAddr, linkWrData, linkWrStrobe, linkRdStrobe} = {~a, ~d, 2'h0};
    repeat (40) begin
      if (linkRdValid) q = linkRdData;
      if (!linkBusy) break;
      @(negedge linkClk);
    end
  endtask
  // stop closes the transfer; restart keeps it open
  task automatic cond(input logic stop);
    @(negedge linkClk);
    {linkStop, linkRestart} = {stop, !stop};
    @(negedge linkClk);
    {linkStop, linkRestart} = 2'h0;
  endtask
endmodule // rtcb_host

//--- test_rtcb_ctrl.sv
module test_rtcb_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcb_pkg::*;
  localparam int RTN = 200; // short hold keeps the run brief
  logic clk = 1'b0, linkClk = 1'b0, rst_b = 1'b0, osc32k = 1'b0;
  logic [2:0] ev = 3'h0;
  logic wrS, rdS, stp, rst2, busy, rdV, intOut, intOe_b, secP, cSt, cEn;
  logic backflow_switch_disable, bkp;
  logic [4:0] addr;
  logic [7:0] wrD, rdD;
  logic [14:0] prescaler;
  int nMismatch = 0, comparisons = 0;

  always #2 clk = ~clk;
  always #8 osc32k = ~osc32k; // fast tick, edges on clk negedges, phase-free of linkClk
  initial begin
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  rtcb_ctrl #(.RTN_CYC(RTN)) dut (.clk(clk), .rst_b(rst_b),
    .linkClk(linkClk), .osc32k(osc32k), .vddLow(1'b0),
    .updateEvent(ev[0]), .timerEvent(ev[1]), .alarmEvent(ev[2]),
    .tempCode(8'h5C), .linkWrStrobe(wrS), .linkRdStrobe(rdS),
    .linkStop(stp), .linkRestart(rst2), .linkAddr(addr),
    .linkWrData(wrD), .linkBusy(busy), .linkRdData(rdD),
    .linkRdValid(rdV), .intOut(intOut), .intOe_b(intOe_b),
    .prescaler(prescaler), .secondPulse(secP), .compStart(cSt),
    .comparator_window_enable(cEn), .supplySwitchOff(backflow_switch_disable), .backupMode(bkp));
  rtcb_host host (.linkClk(linkClk), .linkBusy(busy), .linkRdValid(rdV),
    .linkRdData(rdD), .linkWrStrobe(wrS), .linkRdStrobe(rdS),
    .linkStop(stp), .linkRestart(rst2), .linkAddr(addr),
    .linkWrData(wrD));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [14:0] e, got);
    comparisons++;
    if (got !== e) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
    repeat (6) @(negedge clk); // let the write land in the core
  endtask
  task automatic reg_is(input string nm, input logic [4:0] a,
                        input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    chk(nm, 15'(e), 15'(q));
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    reg_is("ctrl reset", ADDR_CTRL_LO, 8'h40);
  endtask
  task automatic fire(input int k);
    @(negedge clk);
    ev = 3'h1 << k;
    @(negedge clk);
    ev = 3'h0;
    repeat (3) @(negedge clk);
  endtask

  // access kinds, masks, every compensation code, unmapped address
  task automatic t_regs();
    reg_is("thermal", ADDR_THERMAL, 8'h00);
    reg_is("backup", ADDR_BACKUP, 8'h00);
    wr(ADDR_BACKUP, 8'hFF);
    reg_is("backup mask", ADDR_BACKUP, 8'h0F);
    chk("switch off", 15'h1, 15'(backflow_switch_disable));
    chk("no window", 15'h0, 15'({cEn, bkp}));
    wr(ADDR_BACKUP, 8'h00);
    wr(ADDR_THERMAL, 8'hA5);
    reg_is("thermal ro", ADDR_THERMAL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL_HI, 8'(i << 6) | 8'h06);
      reg_is("comp select", ADDR_CTRL_LO, 8'(i << 6));
    end
    wr(5'h05, 8'h5A);
    reg_is("unmapped", 5'h05, 8'h00);
  endtask
  // masked event, enabled event, auto release or hold, cancel by enable
  task automatic t_irq(input int k);
    logic [7:0] m;
    m = 8'h20 >> k;
    wr(ADDR_CTRL_LO, 8'h40);
    fire(k);
    chk("masked int", 15'h1, 15'(intOe_b));
    reg_is("flag set", ADDR_FLAG_LO, m);
    wr(ADDR_FLAG_LO, 8'h00);
    wr(ADDR_CTRL_LO, 8'h40 | m);
    fire(k);
    chk("int low", 15'h0, 15'(intOe_b));
    repeat (RTN - 10) @(negedge clk);
    chk("int held", 15'h0, 15'(intOe_b));
    repeat (20) @(negedge clk);
    chk("int release", 15'(k != 2), 15'(intOe_b));
    wr(ADDR_FLAG_LO, 8'h00);
    chk("flag clear", 15'h1, 15'(intOe_b));
    fire(k);
    wr(ADDR_CTRL_LO, 8'h40);
    chk("int cancel", 15'h1, 15'(intOe_b));
    wr(ADDR_FLAG_LO, 8'h00);
  endtask
  // arm, survive a restart, run at the stop
  task automatic t_resync();
    wr(ADDR_CTRL_LO, 8'h41);
    reg_is("armed", ADDR_CTRL_LO, 8'h41);
    host.cond(1'b0);
    repeat (40) @(negedge clk);
    chk("restart", 15'h1, 15'(prescaler > 15'h0014));
    reg_is("still armed", ADDR_CTRL_LO, 8'h41);
    host.cond(1'b1);
    repeat (12) @(negedge clk);
    chk("divider clear", 15'h1, 15'(prescaler < 15'h0008));
    reg_is("self clear", ADDR_CTRL_LO, 8'h40);
  endtask

  initial begin
    do_reset();
    t_regs();
    for (int k = 0; k < 3; k++) t_irq(k);
    t_resync();
    do_reset();
    stop_test();
  end
  // cut a hang well past the expected run length
  initial begin
    #200000;
    nMismatch++;
    stop_test();
  end
endmodule // test_rtcb_ctrl

bind rtcb_ctrl rtcb_ctrl_chk #(.RTN_CYC(RTN_CYC)) chk (.clk(clk),
  .rst_b(rst_b), .linkClk(linkClk), .updateEvent(updateEvent),
  .timerEvent(timerEvent), .alarmEvent(alarmEvent),
  .linkWrStrobe(linkWrStrobe), .linkBusy(linkBusy),
  .linkRdData(linkRdData), .linkRdValid(linkRdValid), .intOut(intOut),
  .intOe_b(intOe_b), .prescaler(prescaler), .comparator_window_enable(comparator_window_enable),
  .backupMode(backupMode));
